// ---- common/link_enh_pkg.sv ----
// constants for the link enhancement control register block
// assumes a 32-bit configuration access path and a byte-counted async transmit fifo
package link_enh_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] LINK_ENHANCE_CTRL_OFFSET = 8'hF4;
  localparam logic [31:0] LINK_ENHANCE_CTRL_RESET = 32'h0000_1000;
  // writable positions: 15, 13..12, 10, 8, 7, 1; all others read zero
  localparam logic [31:0] LINK_ENHANCE_CTRL_WMASK = 32'h0000_B582;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int REORDER_DISABLE_BIT = 15;
  localparam int START_LEVEL_HI = 13;
  localparam int START_LEVEL_LO = 12;
  localparam int TS_STAMP_BIT = 10;
  localparam int VIDEO_STAMP_BIT = 8;
  localparam int PRIORITY_REQ_BIT = 7;
  localparam int ACCEL_BIT = 1;

  // ------------------------------------------------------------
  // start level encodings and byte thresholds
  // ------------------------------------------------------------
  localparam logic [1:0] LEVEL_STORE_FWD = 2'h0;
  localparam logic [1:0] LEVEL_1K7 = 2'h1;
  localparam logic [1:0] LEVEL_1K = 2'h2;
  localparam logic [1:0] LEVEL_512 = 2'h3;
  localparam int FIFO_LEVEL_W = 12;
  localparam logic [11:0] THRESH_2K_BYTES = 12'h800;
  localparam logic [11:0] THRESH_1K7_BYTES = 12'h6CC;
  localparam logic [11:0] THRESH_1K_BYTES = 12'h400;
  localparam logic [11:0] THRESH_512_BYTES = 12'h200;

  // ------------------------------------------------------------
  // stream format codes that receive timestamp handling
  // ------------------------------------------------------------
  localparam logic [5:0] FMT_TRANSPORT_STREAM = 6'h20;
  localparam logic [5:0] FMT_VIDEO = 6'h00;

endpackage : link_enh_pkg

// ---- hw/async_tx_start_gate.sv ----
// async transmit start decision from fifo level, end token and start level
// assumes fifo level and token flags are synchronous to the system clock
`timescale 1ns/1ps
`default_nettype none
module async_tx_start_gate (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire logic [1:0] start_level,
  input wire logic force_store_fwd,
  // fifo state
  input wire logic [11:0] fifo_level,
  input wire logic eop_in_fifo,
  input wire logic pkt_waiting,
  // decision
  output logic start_q
);

  // ------------------------------------------------------------
  // threshold lookup
  // ------------------------------------------------------------
  function automatic logic [11:0] level_bytes(input logic [1:0] sel);
    case (sel)
      link_enh_pkg::LEVEL_1K7: level_bytes = link_enh_pkg::THRESH_1K7_BYTES;
      link_enh_pkg::LEVEL_1K: level_bytes = link_enh_pkg::THRESH_1K_BYTES;
      link_enh_pkg::LEVEL_512: level_bytes = link_enh_pkg::THRESH_512_BYTES;
      default: level_bytes = link_enh_pkg::THRESH_2K_BYTES;
    endcase
  endfunction : level_bytes

  logic store_fwd;
  logic start_d;

  // store-and-forward waits for the end token only
  always_comb begin
    store_fwd = force_store_fwd || (start_level == link_enh_pkg::LEVEL_STORE_FWD);
    if (!pkt_waiting) begin
      start_d = 1'b0;
    end else if (store_fwd) begin
      start_d = eop_in_fifo;
    end else begin
      start_d = eop_in_fifo || (fifo_level >= level_bytes(start_level));
    end
  end

  // registered so the transmit engine sees a clean level
  always_ff @(posedge clk) begin
    if (rst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_d;
    end
  end

endmodule : async_tx_start_gate
`default_nettype wire

// ---- hw/link_enhancement_control.sv ----
// link enhancement control register and the gating of its enhancements
// assumes configuration and serial eeprom loader writes arrive as one-cycle strobes
// Contract
// - enhancements act only while the phy enhancement gate input is high
// - reserved bits 31-16, 14, 11, 9, 6-2, 0 ignore writes, read zero
// - bit 15 set stops out-of-order async transmit pipelining
// - bits 13-12 give initial transmit threshold, used until first fifo underrun
// - 00 about 2K store-forward, 01 about 1.7K reset, 10 1K, 11 512
// - lower thresholds start at threshold or on a whole packet, whichever first
// - fifo empty mid-packet is underrun; switch to store-and-forward
// - retries use 2K threshold, transmit only with the whole packet held
// - 2K setting waits for end-of-packet token before transmitting
// - retries register cleared forces store-and-forward always
// - bit 10 enables timestamp handling for format code 20h streams
// - bit 8 enables timestamp handling for format code 00h streams
// - bit 7 enables priority arbitration answers; software should set it
// - bit 1 tells the phy the link supports acceleration and concatenation
`timescale 1ns/1ps
`default_nettype none
module link_enhancement_control (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // configuration access
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  output logic CFG_HIT,
  // serial eeprom loader
  input wire logic EE_WR,
  input wire logic [31:0] EE_WDATA,
  // host controller state
  input wire logic PHY_ENHANCE_GATE,
  input wire logic RETRIES_CLEARED,
  // async transmit fifo
  input wire logic [11:0] FIFO_LEVEL,
  input wire logic EOP_IN_FIFO,
  input wire logic PKT_WAITING,
  input wire logic TX_ACTIVE,
  input wire logic FIFO_EMPTY,
  input wire logic RETRY,
  output logic TX_START,
  output logic UNDERRUN,
  output logic STORE_FWD_MODE,
  // isochronous transmit stream
  input wire logic CIP_STREAM,
  input wire logic [5:0] STREAM_FORMAT_CODE,
  output logic STAMP_APPLY,
  // link and phy controls
  output logic ASYNC_TX_REORDER_DISABLE,
  output logic PRIORITY_REQ_ENABLE,
  output logic ACCEL_ENABLE
);

  // ------------------------------------------------------------
  // register storage and access decode
  // ------------------------------------------------------------
  logic [31:0] link_enhance_ctrl_q;
  logic [31:0] link_enhance_ctrl_d;
  logic [31:0] be_mask;
  logic cfg_write;
  logic cfg_read;

  // same address decode serves both directions
  function automatic logic hits_reg(input logic [7:0] addr);
    hits_reg = (addr[7:2] == link_enh_pkg::LINK_ENHANCE_CTRL_OFFSET[7:2]);
  endfunction : hits_reg

  assign cfg_write = CFG_WR && hits_reg(CFG_ADDR);
  assign cfg_read = CFG_RD && hits_reg(CFG_ADDR);

  // byte enables widened to a bit mask
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign be_mask[lane*8 +: 8] = {8{CFG_BE[lane]}};
    end
  endgenerate

  // host write wins over a loader write in the same cycle
  always_comb begin
    link_enhance_ctrl_d = link_enhance_ctrl_q;
    if (cfg_write) begin
      link_enhance_ctrl_d = (link_enhance_ctrl_q & ~(be_mask & link_enh_pkg::LINK_ENHANCE_CTRL_WMASK))
        | (CFG_WDATA & be_mask & link_enh_pkg::LINK_ENHANCE_CTRL_WMASK);
    end else if (EE_WR) begin
      link_enhance_ctrl_d = EE_WDATA & link_enh_pkg::LINK_ENHANCE_CTRL_WMASK;
    end
  end

  // register updates on the edge that completes the write
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      link_enhance_ctrl_q <= link_enh_pkg::LINK_ENHANCE_CTRL_RESET;
    end else begin
      link_enhance_ctrl_q <= link_enhance_ctrl_d;
    end
  end

  // read data registered, one cycle after the strobe; zero when not addressed
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      CFG_RDATA <= 32'h0000_0000;
      CFG_HIT <= 1'b0;
    end else begin
      CFG_HIT <= cfg_read;
      CFG_RDATA <= cfg_read ? (link_enhance_ctrl_q & link_enh_pkg::LINK_ENHANCE_CTRL_WMASK)
        : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // gated enhancement bits
  // ------------------------------------------------------------
  logic reorder_dis_eff;
  logic ts_stamp_eff;
  logic video_stamp_eff;
  logic priority_eff;
  logic accel_eff;
  logic [1:0] start_level_eff;

  // nothing takes effect while the gate is low; level then falls back to store-forward
  always_comb begin
    reorder_dis_eff = PHY_ENHANCE_GATE && link_enhance_ctrl_q[link_enh_pkg::REORDER_DISABLE_BIT];
    ts_stamp_eff = PHY_ENHANCE_GATE && link_enhance_ctrl_q[link_enh_pkg::TS_STAMP_BIT];
    video_stamp_eff = PHY_ENHANCE_GATE && link_enhance_ctrl_q[link_enh_pkg::VIDEO_STAMP_BIT];
    priority_eff = PHY_ENHANCE_GATE && link_enhance_ctrl_q[link_enh_pkg::PRIORITY_REQ_BIT];
    accel_eff = PHY_ENHANCE_GATE && link_enhance_ctrl_q[link_enh_pkg::ACCEL_BIT];
    start_level_eff = PHY_ENHANCE_GATE
      ? link_enhance_ctrl_q[link_enh_pkg::START_LEVEL_HI:link_enh_pkg::START_LEVEL_LO]
      : link_enh_pkg::LEVEL_STORE_FWD;
  end

  // control outputs registered for glitch-free fan-out
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ASYNC_TX_REORDER_DISABLE <= 1'b0;
      PRIORITY_REQ_ENABLE <= 1'b0;
      ACCEL_ENABLE <= 1'b0;
    end else begin
      ASYNC_TX_REORDER_DISABLE <= reorder_dis_eff;
      PRIORITY_REQ_ENABLE <= priority_eff;
      ACCEL_ENABLE <= accel_eff;
    end
  end

  // ------------------------------------------------------------
  // isochronous timestamp selection
  // ------------------------------------------------------------
  logic stamp_d;

  // only the two known format codes are ever stamped
  always_comb begin
    stamp_d = 1'b0;
    if (CIP_STREAM) begin
      case (STREAM_FORMAT_CODE)
        link_enh_pkg::FMT_TRANSPORT_STREAM: stamp_d = ts_stamp_eff;
        link_enh_pkg::FMT_VIDEO: stamp_d = video_stamp_eff;
        default: stamp_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      STAMP_APPLY <= 1'b0;
    end else begin
      STAMP_APPLY <= stamp_d;
    end
  end

  // ------------------------------------------------------------
  // underrun detection and store-and-forward fallback
  // ------------------------------------------------------------
  logic underrun_hit;
  logic fallen_back_q;
  logic force_store_fwd;

  // fifo drained while a packet is still going out and its end is not yet in
  assign underrun_hit = TX_ACTIVE && FIFO_EMPTY && !EOP_IN_FIFO;

  // fallback is sticky until reset: the programmed level is only an initial value
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      fallen_back_q <= 1'b0;
      UNDERRUN <= 1'b0;
    end else begin
      UNDERRUN <= underrun_hit;
      if (underrun_hit) begin
        fallen_back_q <= 1'b1;
      end
    end
  end

  // retry and cleared retry count override any programmed level
  assign force_store_fwd = fallen_back_q || RETRY || RETRIES_CLEARED;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      STORE_FWD_MODE <= 1'b1;
    end else begin
      STORE_FWD_MODE <= force_store_fwd || (start_level_eff == link_enh_pkg::LEVEL_STORE_FWD);
    end
  end

  // ------------------------------------------------------------
  // transmit start decision
  // ------------------------------------------------------------
  async_tx_start_gate async_tx_start_gate_inst (
    .clk(CLK_SYS),
    .rst(RST),
    .start_level(start_level_eff),
    .force_store_fwd(force_store_fwd),
    .fifo_level(FIFO_LEVEL),
    .eop_in_fifo(EOP_IN_FIFO),
    .pkt_waiting(PKT_WAITING),
    .start_q(TX_START)
  );

endmodule : link_enhancement_control
`default_nettype wire

// ---- verif/link_enh_checker.sv ----
// concurrent checks for the link enhancement control block
// assumes binding onto the top module ports, single clock domain
`timescale 1ns/1ps
`default_nettype none
module link_enh_checker (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // configuration access
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  input wire logic [31:0] CFG_RDATA,
  input wire logic CFG_HIT,
  // host state and fifo
  input wire logic PHY_ENHANCE_GATE,
  input wire logic RETRIES_CLEARED,
  input wire logic EOP_IN_FIFO,
  input wire logic TX_ACTIVE,
  input wire logic FIFO_EMPTY,
  input wire logic TX_START,
  input wire logic UNDERRUN,
  input wire logic STORE_FWD_MODE,
  // stream and controls
  input wire logic CIP_STREAM,
  input wire logic [5:0] STREAM_FORMAT_CODE,
  input wire logic STAMP_APPLY,
  input wire logic ASYNC_TX_REORDER_DISABLE,
  input wire logic PRIORITY_REQ_ENABLE,
  input wire logic ACCEL_ENABLE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // --------
  // access steps
  // --------
  sequence s_hit_rd;
    CFG_RD && CFG_ADDR[7:2] == 6'h3D;
  endsequence
  sequence s_full_wr;
    CFG_WR && CFG_ADDR[7:2] == 6'h3D && CFG_BE == 4'hF && CFG_WDATA == 32'hFFFF_FFFF;
  endsequence
  // --------
  // underrun steps
  // --------
  sequence s_underrun_cond;
    TX_ACTIVE && FIFO_EMPTY && !EOP_IN_FIFO;
  endsequence
  // fallback register is set on the underrun edge, so the mode flag follows one cycle later
  sequence s_fallback_held;
    STORE_FWD_MODE[*4];
  endsequence
  // reset check runs while reset is high, so it is never disabled
  AST_RESET_STATE: assert property (disable iff (1'b0) RST |=> !CFG_HIT && CFG_RDATA == 32'h0 && STORE_FWD_MODE)
    else $error("outputs not at reset state");
  AST_READ_HIT: assert property (s_hit_rd |=> CFG_HIT)
    else $error("hit read not answered");
  AST_NO_HIT: assert property (!(CFG_RD && CFG_ADDR[7:2] == 6'h3D) |=> !CFG_HIT && CFG_RDATA == 32'h0)
    else $error("read data without hit read");
  AST_RSVD_ZERO: assert property ((CFG_RDATA & ~link_enh_pkg::LINK_ENHANCE_CTRL_WMASK) == 32'h0)
    else $error("reserved bit read as one");
  AST_WRITE_READBACK: assert property (s_full_wr ##[1:2] s_hit_rd |=> CFG_RDATA == 32'h0000_B582)
    else $error("full write not read back");
  AST_GATED: assert property ((ASYNC_TX_REORDER_DISABLE || PRIORITY_REQ_ENABLE || ACCEL_ENABLE || STAMP_APPLY)
    |-> $past(PHY_ENHANCE_GATE))
    else $error("enhancement active with gate low");
  AST_STAMP_FMT: assert property (STAMP_APPLY |-> $past(CIP_STREAM) &&
    ($past(STREAM_FORMAT_CODE) == 6'h20 || $past(STREAM_FORMAT_CODE) == 6'h00))
    else $error("stamp on wrong stream");
  AST_UNDERRUN: assert property (s_underrun_cond |=> UNDERRUN ##1 s_fallback_held)
    else $error("underrun not flagged or fallback lost");
  AST_RETRIES_SF: assert property (RETRIES_CLEARED |=> STORE_FWD_MODE)
    else $error("retries cleared without store forward");
  AST_SF_START: assert property ($rose(TX_START) && $past(RETRIES_CLEARED) |-> $past(EOP_IN_FIFO))
    else $error("start before end token");
endmodule : link_enh_checker
bind link_enhancement_control link_enh_checker link_enh_checker_inst (.*);
`default_nettype wire

// ---- verif/link_enhancement_control_tb.sv ----
// self-checking bench for the link enhancement control block
// assumes registered outputs follow their inputs one edge later
`timescale 1ns/1ps
`default_nettype none
module link_enhancement_control_tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, ee_wr = 0, gate = 0, rcl = 0, eop = 0, pw = 1, act = 0, emp = 0;
  logic rty = 0, cip = 1, hit, txs, und, sfm, stp, rod, pri, acc;
  logic [7:0] addr = 8'hF4, a;
  logic [3:0] be = 4'hF;
  logic [31:0] wd = 32'h0, ee_d = 32'h0, rdat, mdl, d;
  logic [11:0] lvl = 12'h0;
  logic [5:0] fmt = 6'h0;
  int mismatches = 0, total_checks = 0;
  link_enhancement_control link_enhancement_control_inst (.CLK_SYS(clk), .RST(rst), .CFG_WR(wr), .CFG_RD(rd),
    .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wd), .CFG_RDATA(rdat), .CFG_HIT(hit), .EE_WR(ee_wr),
    .EE_WDATA(ee_d), .PHY_ENHANCE_GATE(gate), .RETRIES_CLEARED(rcl), .FIFO_LEVEL(lvl), .EOP_IN_FIFO(eop),
    .PKT_WAITING(pw), .TX_ACTIVE(act), .FIFO_EMPTY(emp), .RETRY(rty), .TX_START(txs), .UNDERRUN(und),
    .STORE_FWD_MODE(sfm), .CIP_STREAM(cip), .STREAM_FORMAT_CODE(fmt), .STAMP_APPLY(stp),
    .ASYNC_TX_REORDER_DISABLE(rod), .PRIORITY_REQ_ENABLE(pri), .ACCEL_ENABLE(acc));
  // 100 ns clock
  always #50 clk = ~clk;
  // --------
  // helpers
  // --------
  // register after a lane-masked write; reserved bits never stored
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [3:0] m, input logic [31:0] v);
    logic [31:0] k;
    k = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}} & link_enh_pkg::LINK_ENHANCE_CTRL_WMASK;
    return (o & ~k) | (v & k);
  endfunction : merge
  // byte threshold of a start level
  function automatic logic [11:0] thr(input logic [1:0] l);
    return l == 2'h1 ? link_enh_pkg::THRESH_1K7_BYTES : l == 2'h2 ? 12'h400 : l == 2'h3 ? 12'h200 : 12'h800;
  endfunction : thr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cfg_wr(input logic [7:0] x, input logic [3:0] m, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= x;
    be <= m;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : cfg_wr
  // read answer stands right after the edge that takes the strobe
  task automatic cfg_rd(input logic [7:0] x, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= x;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(32'(hit), 32'(x[7:2] == 6'h3D), "hit");
    chk(rdat, exp, "rdata");
  endtask : cfg_rd
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #200us;
    mismatches++;
    finish_test();
  end
  // --------
  // main sequence
  // --------
  initial begin
    d = $urandom(14235);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    mdl = 32'h0000_1000;
    cfg_rd(8'hF4, mdl);
    cfg_wr(8'hF4, 4'hF, 32'hFFFF_FFFF);
    mdl = 32'h0000_B582;
    cfg_rd(8'hF4, mdl);
    // random lane writes, some to the unmapped neighbour
    for (int i = 0; i < 24; i++) begin
      d = $urandom();
      a = {d[31] ? 6'h3E : 6'h3D, d[29:28]};
      cfg_wr(a, d[27:24], $urandom());
      if (a[7:2] == 6'h3D) mdl = merge(mdl, d[27:24], wd);
      cfg_rd(a, a[7:2] == 6'h3D ? mdl : 32'h0);
    end
    // loader replaces the whole register
    d = $urandom();
    @(posedge clk);
    ee_wr <= 1'b1;
    ee_d <= d;
    @(posedge clk);
    ee_wr <= 1'b0;
    cfg_rd(8'hF4, d & link_enh_pkg::LINK_ENHANCE_CTRL_WMASK);
    cfg_wr(8'hF4, 4'hF, 32'hFFFF_FFFF);
    for (int g = 0; g < 2; g++) begin
      gate <= g[0];
      settle();
      chk(32'({rod, pri, acc}), 32'({3{g[0]}}), "controls");
    end
    // stamp enables against format codes
    for (int k = 0; k < 12; k++) begin
      cfg_wr(8'hF4, 4'h2, {21'h0, k[1], 1'b0, k[0], 8'h00});
      fmt <= k[3:2] == 0 ? 6'h00 : k[3:2] == 1 ? 6'h20 : 6'h15;
      cip <= k != 1;
      settle();
      chk(32'(stp), 32'(cip && ((fmt == 6'h20 && k[1]) || (fmt == 6'h00 && k[0]))), "stamp");
    end
    // each start level: below, at threshold, small whole packet
    for (int l = 0; l < 4; l++) begin
      cfg_wr(8'hF4, 4'h2, {18'h0, l[1:0], 12'h0});
      for (int e = 0; e < 3; e++) begin
        lvl <= e == 2 ? 12'($urandom_range(255, 1)) : thr(l[1:0]) - 12'(e == 0);
        eop <= e == 2;
        settle();
        chk(32'(txs), 32'(e == 2 || (e == 1 && l != 0)), "start");
        chk(32'(sfm), 32'(l == 0), "sf mode");
      end
    end
    // no packet waiting: nothing may start even with the token in
    pw <= 1'b0;
    settle();
    chk(32'(txs), 32'h0, "idle start");
    pw <= 1'b1;
    lvl <= 12'h7FF;
    // forced store-and-forward holds off above threshold, then starts on the token
    for (int c = 0; c < 2; c++) begin
      rcl <= c == 0;
      rty <= c == 1;
      eop <= 1'b0;
      settle();
      chk(32'(txs), 32'h0, "forced sf");
      eop <= 1'b1;
      settle();
      chk(32'(txs), 32'h1, "forced sf token");
    end
    rcl <= 1'b0;
    rty <= 1'b0;
    eop <= 1'b0;
    // one cycle of underrun, then fallback must stick
    @(posedge clk);
    act <= 1'b1;
    emp <= 1'b1;
    @(posedge clk);
    act <= 1'b0;
    emp <= 1'b0;
    #1;
    chk(32'(und), 32'h1, "underrun");
    settle();
    chk(32'({txs, sfm}), 32'h1, "fallback");
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk(32'(sfm), 32'h0, "reset level");
    cfg_rd(8'hF4, 32'h0000_1000);
    finish_test();
  end
endmodule : link_enhancement_control_tb
`default_nettype wire
